// >>> common/psc_pll_map.vh
// register map, field positions and reset values of the loop setup control block
`ifndef PSC_PLL_MAP_VH
`define PSC_PLL_MAP_VH

// ----------------------------------------------------------------------------
// register word indices (byte address = index * 4)
// ----------------------------------------------------------------------------
`define PSC_IDX_CONTROL     10'h089
`define PSC_IDX_REF_DIV     10'h08a
`define PSC_IDX_FILTER      10'h08b
`define PSC_IDX_MULT        10'h08c
`define PSC_IDX_IRQ_STATUS  10'h08d
`define PSC_IDX_IRQ_MASK    10'h08e

// ----------------------------------------------------------------------------
// pll_control fields
// ----------------------------------------------------------------------------
`define PSC_CTL_BIAS_BIT    0
`define PSC_CTL_EN_BIT      1
`define PSC_CTL_SRC_BIT     2
`define PSC_CTL_LOCK_BIT    4

// ----------------------------------------------------------------------------
// loop_filter_config fields
// ----------------------------------------------------------------------------
`define PSC_FLT_RANGE_LSB   0
`define PSC_FLT_RANGE_MSB   3
`define PSC_FLT_ICO_LSB     4
`define PSC_FLT_ICO_MSB     5

// ----------------------------------------------------------------------------
// interrupt status / mask fields
// ----------------------------------------------------------------------------
`define PSC_IRQ_GAINED_BIT  0
`define PSC_IRQ_LOST_BIT    1

// ----------------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------------
`define PSC_RST_BYTE        8'h00
`define PSC_RST_IRQ         2'h0
`define PSC_LOCK_SETTLE     16'h0040

`endif

// >>> hdl/psc_lock_qualifier.v
// qualifies the raw analog lock indication into the lock flag
`include "psc_pll_map.vh"

module psc_lock_qualifier #(
  parameter [15:0] SETTLE_CYCLES = `PSC_LOCK_SETTLE
) (
  input  wire core_clk,
  input  wire rst_b,
  input  wire loopRun,
  input  wire lockRaw,
  output reg  lockFlag_q
);

  reg [15:0] settleCnt_q;

  // ----------------------------------------------------------------------------
  // settle counter
  // ----------------------------------------------------------------------------
  // a glitchy comparator must hold steady before lock is claimed
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      settleCnt_q <= 16'h0000;
      lockFlag_q  <= 1'b0;
    end else if (!loopRun || !lockRaw) begin
      settleCnt_q <= 16'h0000;
      lockFlag_q  <= 1'b0;
    end else if (settleCnt_q >= SETTLE_CYCLES) begin
      lockFlag_q  <= 1'b1;
    end else begin
      settleCnt_q <= settleCnt_q + 16'h0001;
    end
  end

endmodule // psc_lock_qualifier

// >>> hdl/psc_pll_setup_control.v
// wishbone register block controlling the system clock multiplier loop
//
// The Wishbone slave port was decided locally.
`include "psc_pll_map.vh"

module psc_pll_setup_control #(
  parameter [15:0] SETTLE_CYCLES = `PSC_LOCK_SETTLE
) (
  input  wire        core_clk,
  input  wire        rst_b,
  // wishbone classic slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [11:0] adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // analog loop
  input  wire        lockRaw,
  output wire        biasPowerOn,
  output wire        loopEnable,
  output wire        refSourceSelect,
  output wire [7:0]  refDivider,
  output wire [3:0]  loopFilterRange,
  output wire [1:0]  oscCurrentRange,
  output wire [7:0]  multiplierFactor,
  // interrupt
  output wire        irqOut
);

  reg  [2:0] ctl_q;
  reg  [7:0] refDiv_q;
  reg  [5:0] filter_q;
  reg  [7:0] mult_q;
  reg  [1:0] irqStatus_q;
  reg  [1:0] irqMask_q;
  reg        lockPrev_q;
  reg  [31:0] rdData_d;
  wire        lockFlag;
  wire        lockGained;
  wire        lockLost;
  wire        wrStrobe;
  wire        lane0Wr;
  wire [9:0]  wordIdx;

  function hit;
    input [9:0] idx;
    input [9:0] target;
    begin
      hit = (idx == target);
    end
  endfunction

  // ----------------------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------------------
  // one wait state: data is registered, ack follows the request by one edge
  assign wordIdx  = adr_i[11:2];
  assign wrStrobe = cyc_i && stb_i && we_i && ack_o;
  assign lane0Wr  = wrStrobe && sel_i[0];

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
      if (cyc_i && stb_i && !ack_o && !we_i) begin
        dat_o <= rdData_d;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------------
  // unmapped words answer normally with zero data
  always @* begin
    rdData_d = 32'h00000000;
    if (hit(wordIdx, `PSC_IDX_CONTROL)) begin
      rdData_d[`PSC_CTL_LOCK_BIT] = lockFlag;
      rdData_d[`PSC_CTL_SRC_BIT]  = ctl_q[2];
      rdData_d[`PSC_CTL_EN_BIT]   = ctl_q[1];
      rdData_d[`PSC_CTL_BIAS_BIT] = ctl_q[0];
    end else if (hit(wordIdx, `PSC_IDX_REF_DIV)) begin
      rdData_d[7:0] = refDiv_q;
    end else if (hit(wordIdx, `PSC_IDX_FILTER)) begin
      rdData_d[5:0] = filter_q;
    end else if (hit(wordIdx, `PSC_IDX_MULT)) begin
      rdData_d[7:0] = mult_q;
    end else if (hit(wordIdx, `PSC_IDX_IRQ_STATUS)) begin
      rdData_d[1:0] = irqStatus_q;
    end else if (hit(wordIdx, `PSC_IDX_IRQ_MASK)) begin
      rdData_d[1:0] = irqMask_q;
    end
  end

  // ----------------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------------
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_q     <= 3'h0;
      refDiv_q  <= `PSC_RST_BYTE;
      filter_q  <= 6'h00;
      mult_q    <= `PSC_RST_BYTE;
      irqMask_q <= `PSC_RST_IRQ;
    end else if (lane0Wr) begin
      if (hit(wordIdx, `PSC_IDX_CONTROL)) begin
        // bias and enable may drop in one write
        ctl_q <= {dat_i[`PSC_CTL_SRC_BIT], dat_i[`PSC_CTL_EN_BIT],
                  dat_i[`PSC_CTL_BIAS_BIT]};
      end
      if (hit(wordIdx, `PSC_IDX_REF_DIV)) begin
        refDiv_q <= dat_i[7:0];
      end
      if (hit(wordIdx, `PSC_IDX_FILTER)) begin
        filter_q <= dat_i[5:0];
      end
      if (hit(wordIdx, `PSC_IDX_MULT)) begin
        mult_q <= dat_i[7:0];
      end
      if (hit(wordIdx, `PSC_IDX_IRQ_MASK)) begin
        irqMask_q <= dat_i[1:0];
      end
    end
  end

  assign biasPowerOn      = ctl_q[0];
  assign loopEnable       = ctl_q[1];
  assign refSourceSelect  = ctl_q[2];
  // the analog loop forms ref * multiplier / divider from these
  assign refDivider       = refDiv_q;
  assign multiplierFactor = mult_q;
  assign loopFilterRange  = filter_q[`PSC_FLT_RANGE_MSB:`PSC_FLT_RANGE_LSB];
  assign oscCurrentRange  = filter_q[`PSC_FLT_ICO_MSB:`PSC_FLT_ICO_LSB];

  // ----------------------------------------------------------------------------
  // lock qualification
  // ----------------------------------------------------------------------------
  psc_lock_qualifier #(
    .SETTLE_CYCLES (SETTLE_CYCLES)
  ) uLock (
    .core_clk   (core_clk),
    .rst_b      (rst_b),
    .loopRun    (ctl_q[0] && ctl_q[1]),
    .lockRaw    (lockRaw),
    .lockFlag_q (lockFlag)
  );

  // ----------------------------------------------------------------------------
  // interrupt status
  // ----------------------------------------------------------------------------
  // a new event beats a write-one-to-clear in the same cycle
  assign lockGained = lockFlag && !lockPrev_q;
  assign lockLost   = !lockFlag && lockPrev_q;

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lockPrev_q  <= 1'b0;
      irqStatus_q <= `PSC_RST_IRQ;
    end else begin
      lockPrev_q <= lockFlag;
      irqStatus_q[`PSC_IRQ_GAINED_BIT] <= lockGained ||
        (irqStatus_q[`PSC_IRQ_GAINED_BIT] &&
         !(lane0Wr && hit(wordIdx, `PSC_IDX_IRQ_STATUS) && dat_i[0]));
      irqStatus_q[`PSC_IRQ_LOST_BIT] <= lockLost ||
        (irqStatus_q[`PSC_IRQ_LOST_BIT] &&
         !(lane0Wr && hit(wordIdx, `PSC_IDX_IRQ_STATUS) && dat_i[1]));
    end
  end

  assign irqOut = |(irqStatus_q & irqMask_q);

endmodule // psc_pll_setup_control

// >>> verif/psc_pll_sva.sv
// checker of the loop setup control block ports
`include "psc_pll_map.vh"
module psc_pll_sva (
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        lockRaw,
  input wire logic        biasPowerOn,
  input wire logic        loopEnable,
  input wire logic        refSourceSelect,
  input wire logic [7:0]  refDivider,
  input wire logic [7:0]  multiplierFactor,
  input wire logic        irqOut
);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire wr = cyc_i && stb_i && ack_o && we_i && sel_i[0];
  wire wCtl = wr && adr_i[11:2] == `PSC_IDX_CONTROL;
  wire rCtl = cyc_i && stb_i && ack_o && !we_i && adr_i[11:2] == `PSC_IDX_CONTROL;
  wire run = loopEnable && biasPowerOn;
  ack_one_a: assert property (ack_o |=> !ack_o) else $error("ack held too long");
  ack_due_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing");
  src_sel_a: assert property (wCtl |=> refSourceSelect == $past(dat_i[2]))
    else $error("source select not written");
  loop_en_a: assert property (wCtl |=> loopEnable == $past(dat_i[1]))
    else $error("loop enable not written");
  bias_pwr_a: assert property (wCtl |=> biasPowerOn == $past(dat_i[0]))
    else $error("bias power not written");
  ctl_unused_a: assert property (rCtl |-> dat_o[7:5] == 3'h0 && !dat_o[3])
    else $error("unused control bits not zero");
  ctl_readback_a: assert property (rCtl |-> dat_o[2:0] == {refSourceSelect, loopEnable,
    biasPowerOn}) else $error("control readback wrong");
  div_val_a: assert property (wr && adr_i[11:2] == `PSC_IDX_REF_DIV |=>
    refDivider == $past(dat_i[7:0])) else $error("divider not written");
  mul_val_a: assert property (wr && adr_i[11:2] == `PSC_IDX_MULT |=>
    multiplierFactor == $past(dat_i[7:0])) else $error("multiplier not written");
  lock_off_a: assert property (rCtl && !run && !$past(run) && !$past(run, 2) &&
    !$past(run, 3) |-> !dat_o[4]) else $error("lock flag set while stopped");
  lock_src_a: assert property (rCtl && dat_o[4] |-> $past(lockRaw, 4) && $past(run, 4))
    else $error("lock flag without raw lock");
  cover property (rCtl && dat_o[4]);
  cover property (irqOut);
  cover property (ack_o && adr_i[11:2] == 10'h0ff);
endmodule // psc_pll_sva

bind psc_pll_setup_control psc_pll_sva u_sva (.*);

// >>> verif/tb_top.sv
// self-checking bench of the loop setup control block
`include "psc_pll_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] CT = `PSC_IDX_CONTROL;
  localparam logic [9:0] ST = `PSC_IDX_IRQ_STATUS;
  localparam logic [9:0] MK = `PSC_IDX_IRQ_MASK;
  logic core_clk, rst_b, cyc, we, lockRaw, ack, bias, en, src, irq;
  logic [3:0]  selV, flt;
  logic [11:0] adr;
  logic [31:0] dat, datO;
  logic [7:0]  div, mul, r;
  logic [1:0]  ico;
  int n_mismatch, compares;
  psc_pll_setup_control #(.SETTLE_CYCLES(16'h0004)) u_dut (.core_clk(core_clk),
    .rst_b(rst_b), .cyc_i(cyc), .stb_i(cyc), .we_i(we), .adr_i(adr), .sel_i(selV),
    .dat_i(dat), .dat_o(datO), .ack_o(ack), .lockRaw(lockRaw), .biasPowerOn(bias),
    .loopEnable(en), .refSourceSelect(src), .refDivider(div), .loopFilterRange(flt),
    .oscCurrentRange(ico), .multiplierFactor(mul), .irqOut(irq));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic results();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  // ack and data are read at the rising edge, before that edge's updates land
  task automatic bus(input logic w, input logic [9:0] i, input logic [7:0] d);
    int n;
    @(posedge core_clk);
    cyc <= 1'b1;
    we <= w;
    adr <= {i, 2'h0};
    dat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED %0t no ack", $time);
      results();
    end
    r = datO[7:0];
    cyc <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h00);
    chk(r, e);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    rst_b = 1'b0;
    cyc = 1'b0;
    we = 1'b0;
    adr = 12'h000;
    dat = 32'h0;
    selV = 4'hf;
    lockRaw = 1'b0;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 6; i++) rd(CT + 10'(i), 8'h00);
    bus(1'b1, 10'h0ff, 8'hff);
    rd(10'h0ff, 8'h00);
    selV <= 4'h0;
    bus(1'b1, CT, 8'hff);
    selV <= 4'hf;
    rd(CT, 8'h00);
    bus(1'b1, CT, 8'hfd);
    rd(CT, 8'h05);
    chk({5'h0, src, en, bias}, 8'h05);
    bus(1'b1, `PSC_IDX_REF_DIV, 8'h5a);
    bus(1'b1, `PSC_IDX_FILTER, 8'h2b);
    bus(1'b1, `PSC_IDX_MULT, 8'hc3);
    rd(`PSC_IDX_FILTER, 8'h2b);
    chk({2'h0, ico, flt}, 8'h2b);
    chk(div, 8'h5a);
    chk(mul, 8'hc3);
    repeat (500) @(posedge core_clk);
    bus(1'b1, CT, 8'h03);
    bus(1'b1, MK, 8'h03);
    rd(CT, 8'h03);
    chk({7'h0, src}, 8'h00);
    @(posedge core_clk);
    lockRaw <= 1'b1;
    for (int k = 0; k < 40 && r[4] !== 1'b1; k++) bus(1'b0, CT, 8'h00);
    chk(r, 8'h13);
    rd(ST, 8'h01);
    chk({7'h0, irq}, 8'h01);
    bus(1'b1, ST, 8'h01);
    rd(ST, 8'h00);
    chk({7'h0, irq}, 8'h00);
    // reconfigure while running: disable first, then a fresh lock is needed
    bus(1'b1, CT, 8'h01);
    bus(1'b1, `PSC_IDX_MULT, 8'h3c);
    rd(CT, 8'h01);
    chk(mul, 8'h3c);
    bus(1'b1, CT, 8'h03);
    for (int k = 0; k < 40 && r[4] !== 1'b1; k++) bus(1'b0, CT, 8'h00);
    chk(r, 8'h13);
    rd(ST, 8'h03);
    bus(1'b1, ST, 8'h03);
    rd(ST, 8'h00);
    bus(1'b1, CT, 8'h00);
    rd(CT, 8'h00);
    rd(ST, 8'h02);
    chk({7'h0, irq}, 8'h01);
    bus(1'b1, MK, 8'h01);
    rd(MK, 8'h01);
    chk({7'h0, irq}, 8'h00);
    bus(1'b1, CT, 8'h02);
    repeat (12) @(posedge core_clk);
    rd(CT, 8'h02);
    results();
  end
endmodule // tb_top
